/* File: rtl/tcs_pkg.sv */
/*
  constants for the tuning capacitor serial control port.
  assumes a sv-2012 tool; no surrounding logic needed.
*/
package tcs_pkg;
  localparam int unsigned WORD_W = 8;
  localparam logic [7:0] CTRL_WORD_RST = 8'h00;
  localparam int unsigned STANDBY_POS = 5;
  localparam int unsigned CAP_BIT3_POS = 3;
  localparam int unsigned CAP_BIT2_POS = 2;
  localparam int unsigned CAP_BIT1_POS = 1;
  localparam int unsigned CAP_BIT0_POS = 0;
  localparam int unsigned RSVD_HI_POS = 7;
  localparam int unsigned RSVD_MID_POS = 6;
  localparam int unsigned RSVD_LO_POS = 4;
  localparam int unsigned SYNC_STAGES = 2;
  localparam real ENABLE_SETUP_NS = 19.2;
  localparam real ENABLE_HOLD_NS = 19.2;
  localparam real ENABLE_LOW_NS = 38.4;
  localparam real SYS_PERIOD_NS = 20.0;
  localparam int unsigned ENABLE_LOW_CYC =
    (ENABLE_LOW_NS / SYS_PERIOD_NS) < 1.0 ? 1 :
    int'($ceil(ENABLE_LOW_NS / SYS_PERIOD_NS));
  typedef enum logic [1:0] {
    TCS_IDLE = 2'b01,
    TCS_FRAME = 2'b10
  } tcs_state_type;
endpackage

/* File: rtl/tcs_sync.sv */
/*
  two-flop level synchroniser into the system clock.
  assumes an asynchronous input and an active-low async reset.
*/
`timescale 1ns/10ps
module tcs_sync #(
  parameter int unsigned STAGES = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  import tcs_pkg::*;

  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_nxt;

  initial begin
    if (STAGES < 2) begin
      $error("tcs_sync needs at least two stages");
    end
  end

  always_comb begin
    chain_nxt = {chain_r[STAGES-2:0], async_in};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign sync_out = chain_r[STAGES-1];
endmodule

/* File: rtl/tcs_top.sv */
/*
  write-only three-wire control port of a tunable capacitor: shifts
  telegrams on the serial clock, applies them in the system domain.
  assumes a serial master that keeps the framing and timing of the port.
*/
`timescale 1ns/10ps
// Function
// (RULE1) master raises the enable before any clock pulse of a telegram.
// (RULE2) one data bit taken per rising serial clock, msb first.
// (RULE3) master changes data only on falling serial clock edges.
// (RULE4) shifted word applied on falling enable, never earlier.
// (RULE5) no bit counting; only the last eight bits are applied.
// (RULE6) shifting happens only while this device's enable is high.
// (RULE7) with shared enable, master sends every device a full word.
// (RULE8) master writes zero into bits seven, six and four.
// (RULE9) bit five zero means active, one means low-current standby.
// (RULE10) low four bits give the binary capacitance state, bit three msb.
// (RULE11) enable leads first clock and trails last clock by 19.2 ns.
// (RULE12) enable stays low at least 38.4 ns between telegrams.
// (RULE13) no readback or acknowledge output exists.
module tcs_top #(
  parameter int unsigned WIDTH = tcs_pkg::WORD_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_select_line,
  output logic standby_select,
  output logic cap_state_bit3,
  output logic cap_state_bit2,
  output logic cap_state_bit1,
  output logic cap_state_bit0,
  output logic [tcs_pkg::WORD_W-1:0] tuning_control_word,
  output logic word_applied
);
  import tcs_pkg::*;

  initial begin
    if (WIDTH != WORD_W) begin
      $error("tcs_top serves only eight-bit telegrams");
    end
  end

  // serial clock domain shift register
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;

  always_comb begin
    shift_nxt = shift_r;
    if (latch_select_line) begin // see (RULE6)
      shift_nxt = {shift_r[WORD_W-2:0], serial_data}; // see (RULE2) (RULE5)
    end
  end

  // data sampled on rising edge, master moves it on falling edge
  always_ff @(posedge serial_clk or negedge rst_n) begin // see (RULE3)
    if (!rst_n) begin
      shift_r <= CTRL_WORD_RST;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // enable brought into the system domain
  logic enable_sync;

  tcs_sync #(
    .STAGES(SYNC_STAGES)
  ) u_enable_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(latch_select_line),
    .sync_out(enable_sync)
  );

  // framing state and word capture
  tcs_state_type state_r;
  tcs_state_type state_nxt;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] word_nxt;
  logic applied_r;
  logic applied_nxt;

  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    applied_nxt = 1'b0;
    case (state_r)
      TCS_IDLE: begin
        if (enable_sync) begin // see (RULE1)
          state_nxt = TCS_FRAME;
        end
      end
      TCS_FRAME: begin
        // shift register is quiet once enable is low
        if (!enable_sync) begin // see (RULE4) (RULE12)
          word_nxt = shift_r; // see (RULE5)
          applied_nxt = 1'b1;
          state_nxt = TCS_IDLE;
        end
      end
      default: begin
        state_nxt = TCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TCS_IDLE;
      word_r <= CTRL_WORD_RST;
      applied_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      applied_r <= applied_nxt;
    end
  end

  // decoded control state; reserved bits are kept but steer nothing
  assign standby_select = word_r[STANDBY_POS]; // see (RULE9)
  assign cap_state_bit3 = word_r[CAP_BIT3_POS]; // see (RULE10)
  assign cap_state_bit2 = word_r[CAP_BIT2_POS]; // see (RULE10)
  assign cap_state_bit1 = word_r[CAP_BIT1_POS]; // see (RULE10)
  assign cap_state_bit0 = word_r[CAP_BIT0_POS]; // see (RULE10)
  assign tuning_control_word = word_r;
  // system-side strobe output only, nothing goes back to the master
  assign word_applied = applied_r; // see (RULE13)
endmodule

/* File: sim/tcs_props.sv */
/* checker on tcs_top ports.
   assumes a bind from the bench top. */
`timescale 1ns/10ps
module tcs_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic latch_select_line,
  input wire logic standby_select,
  input wire logic cap_state_bit3,
  input wire logic cap_state_bit2,
  input wire logic cap_state_bit1,
  input wire logic cap_state_bit0,
  input wire logic [7:0] tuning_control_word,
  input wire logic word_applied
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_fall; $fell(latch_select_line); endsequence
  sequence s_busy; latch_select_line [*3]; endsequence
  property p_stb; standby_select == tuning_control_word[5]; endproperty
  property p_cap; {cap_state_bit3, cap_state_bit2, cap_state_bit1,
    cap_state_bit0} == tuning_control_word[3:0]; endproperty
  property p_late; s_fall |-> ##[2:5] word_applied; endproperty
  property p_hold; !word_applied |-> $stable(tuning_control_word);
  endproperty
  property p_frame; word_applied |-> !latch_select_line; endproperty
  property p_pulse; word_applied |=> !word_applied; endproperty
  property p_busy; s_busy |=> $stable(tuning_control_word); endproperty
  a_stb: assert property (p_stb)
    else $error("standby bit");
  a_cap: assert property (p_cap)
    else $error("state bits");
  a_late: assert property (p_late)
    else $error("no apply");
  a_hold: assert property (p_hold)
    else $error("early word");
  a_frame: assert property (p_frame)
    else $error("apply in frame");
  a_pulse: assert property (p_pulse)
    else $error("long pulse");
  a_busy: assert property (p_busy)
    else $error("counted bits");
endmodule

/* File: sim/tcs_master.sv */
/* serial master model.
   assumes calls from the bench. */
`timescale 1ns/10ps
module tcs_master (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_select_line
);
  initial serial_clk = 1'b0;
  initial serial_data = 1'b0;
  initial latch_select_line = 1'b0;
  task automatic send(input logic [11:0] b, input int n);
    #100;
    latch_select_line = 1'b1;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = b[i];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    #20 latch_select_line = 1'b0;
    serial_data = ~serial_data;
  endtask
  // clocks with enable low, meant for another device
  task automatic stray(input logic [7:0] b);
    #100;
    for (int i = 7; i >= 0; i--) begin
      serial_data = b[i];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    #20 serial_data = 1'b0;
  endtask
endmodule

/* File: sim/test_tuning_cap_serial_control.sv */
/* bench for tcs_top.
   assumes tcs_master and tcs_props. */
`timescale 1ns/10ps
module test_tuning_cap_serial_control;
  logic clk_sys, rst_n, serial_clk, serial_data, latch_select_line;
  logic standby_select, cap_state_bit3, cap_state_bit2, cap_state_bit1;
  logic cap_state_bit0, word_applied;
  logic [7:0] tuning_control_word;
  int err_count = 0, check_count = 0, cyc = 0;
  logic [23:0] rows [4] = '{24'h02f82f, 24'h00a80a, 24'hf22c22,
    24'h009429};
  tcs_master i_tcs_master (.serial_clk, .serial_data, .latch_select_line);
  tcs_top i_tcs_top (.clk_sys, .rst_n, .serial_clk, .serial_data,
    .latch_select_line, .standby_select, .cap_state_bit3, .cap_state_bit2,
    .cap_state_bit1, .cap_state_bit0, .tuning_control_word, .word_applied);
  task automatic chk(input logic [13:0] e);
    logic [13:0] g;
    g = {word_applied, standby_select, cap_state_bit3, cap_state_bit2,
      cap_state_bit1, cap_state_bit0, tuning_control_word};
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value outputs exp %h got %h", e, g);
    end
  endtask
  task automatic run(input logic [11:0] b, input int n, input logic [7:0] e);
    i_tcs_master.send(b, n);
    for (int k = 0; k < 10 && word_applied !== 1'b1; k++)
      @(posedge clk_sys) #1;
    chk({1'b1, e[5], e[3:0], e});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk(14'h0000);
    foreach (rows[r]) run(rows[r][23:12], rows[r][11:8], rows[r][7:0]);
    for (int s = 0; s < 16; s++) run(12'(s), 8, 8'(s));
    run(12'h001, 8, 8'h01);
    i_tcs_master.stray(8'hff);
    run(12'h000, 1, 8'h02);
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk(14'h0000);
    run(12'h001, 2, 8'h01);
    end_of_test();
  end
endmodule
bind tcs_top tcs_props i_tcs_props (.clk_sys, .rst_n, .latch_select_line,
  .standby_select, .cap_state_bit3, .cap_state_bit2, .cap_state_bit1,
  .cap_state_bit0, .tuning_control_word, .word_applied);
